// ---- scsr_defines.vh ----
`ifndef SCSR_DEFINES_VH
`define SCSR_DEFINES_VH

// register offsets
`define SCSR_ADDR_DEEP_REST_PERIOD 8'h18
`define SCSR_ADDR_LIGHT_CTRL 8'h1a
`define SCSR_ADDR_IF_MODE 8'h1c
`define SCSR_ADDR_EVENT_CTRL 8'h1d
`define SCSR_ADDR_DUMP_CTRL 8'h28
`define SCSR_ADDR_FRAME_OBS 8'h2e
`define SCSR_ADDR_PIN_STATE 8'h31
`define SCSR_ADDR_PIN_TEST_LVL 8'h33
`define SCSR_ADDR_PIN_TEST_EN 8'h34
`define SCSR_ADDR_SOFT_RESET 8'h3a

// reset values
`define SCSR_RST_DEEP_REST_PERIOD 8'h31
`define SCSR_RST_LIGHT_CTRL 8'h00
`define SCSR_RST_EVENT_CTRL 8'h04
`define SCSR_RST_DUMP_CTRL 8'h00
`define SCSR_RST_FRAME_OBS 8'h00
`define SCSR_RST_PIN_TEST_LVL 8'h00

// soft reset key
`define SCSR_SOFT_RESET_KEY 8'h5a

// field positions
`define SCSR_LIGHT_ON_BIT 3
`define SCSR_LIGHT_CODE_MSB 2
`define SCSR_IF_BURST_BIT 4
`define SCSR_IF_SPI_BIT 2
`define SCSR_IF_TWI_BIT 0
`define SCSR_EVT_POL_BIT 7
`define SCSR_EVT_MASK_MSB 3
`define SCSR_DUMP_EN_BIT 0
`define SCSR_OBS_MODE_LSB 6
`define SCSR_TEST_EN_BIT 4
`define SCSR_TEST_EVENT_BIT 3
`define SCSR_TEST_GPIO_BIT 2
`define SCSR_TEST_MOSI_BIT 1
`define SCSR_TEST_MISO_BIT 0

// light drive codes and their currents in tenths of a milliamp
`define SCSR_LIGHT_CODE_13MA 3'h0
`define SCSR_LIGHT_CODE_9P6MA 3'h2
`define SCSR_LIGHT_CODE_27MA 3'h7
`define SCSR_LIGHT_DMA_13MA 9'h082
`define SCSR_LIGHT_DMA_9P6MA 9'h060
`define SCSR_LIGHT_DMA_27MA 9'h10e

// timing: hibernate tick of 10 ms from the 50 MHz system clock
`define SCSR_SYS_CLK_HZ 50000000
`define SCSR_HIB_TICK_MS 10
`define SCSR_HIB_TICK_CYC ((`SCSR_SYS_CLK_HZ / 1000) * `SCSR_HIB_TICK_MS)

`endif

// ---- scsr_frame_timer.v ----
`timescale 1ns/1ps
`default_nettype none
`include "scsr_defines.vh"

module scsr_frame_timer #(
  parameter HIB_TICK_CYC = `SCSR_HIB_TICK_CYC
) (
  input wire clk,
  input wire rstn,
  input wire restart,
  input wire [7:0] period,
  output reg frame_tick
);

  reg [19:0] div_reg;
  reg hib_tick_reg;
  reg [8:0] tick_cnt_reg;

  // slow hibernate clock as a one-cycle enable; restart keeps phases aligned after soft reset
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 20'h0_0000;
      hib_tick_reg <= 1'b0;
    end else if (restart || div_reg == HIB_TICK_CYC - 1) begin
      div_reg <= 20'h0_0000;
      hib_tick_reg <= !restart;
    end else begin
      div_reg <= div_reg + 20'h0_0001;
      hib_tick_reg <= 1'b0;
    end
  end

  // frame every (period + 1) hibernate ticks; a new period is compared from the next hibernate tick on
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_reg <= 9'h000;
      frame_tick <= 1'b0;
    end else if (restart) begin
      tick_cnt_reg <= 9'h000;
      frame_tick <= 1'b0;
    end else if (hib_tick_reg) begin
      if (tick_cnt_reg >= {1'b0, period}) begin
        tick_cnt_reg <= 9'h000;
        frame_tick <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 9'h001;
        frame_tick <= 1'b0;
      end
    end else begin
      frame_tick <= 1'b0;
    end
  end

endmodule // scsr_frame_timer
`default_nettype wire

// ---- scsr_regs.v ----
// Functional notes
// - the deepest rest frame period is (period field + 1) times the 10 ms hibernate tick.
// - the deepest rest period defaults to 500 ms and the host keeps it between 20 ms and 2.41 s.
// - the always-lit bit at 0 runs the light normally and at 1 keeps it lit.
// - the 3-bit drive code selects 13 mA at 0, 9.6 mA at 2 and 27 mA at 7.
// - the interface status shows burst on bit 4, serial peripheral on bit 2 and two-wire on bit 0.
// - bit 7 of the event control makes the event pin active low at 0 and active high at 1.
// - event control bits 3..0 mask soft click, finger presence, button click and motion, finger masked at reset.
// - writing 1 to the dump enable bit enables and starts an image dump, 0 disables it.
// - the observation bits are set every frame and a host write to that register clears them unless a frame comes in the same cycle.
// - observation bits 7:6 report the power mode, 00 run up to 11 third rest.
// - four 2-bit pin state fields report reset, shutdown, general and interface-select pins.
// - in pin test the event, general, master-out and master-in pins follow test bits 3..0.
// - bit 4 of the write-only pad function register enters output pin test.
// - writing 0x5A to the soft reset register returns every setting to its default.
`timescale 1ns/1ps
`default_nettype none
`include "scsr_defines.vh"

module scsr_regs #(
  parameter HIB_TICK_CYC = `SCSR_HIB_TICK_CYC
) (
  input wire clk,
  input wire rstn,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire burst_mode,
  input wire spi_mode,
  input wire twi_mode,
  input wire [1:0] power_mode,
  input wire frame_done,
  input wire [7:0] pad_state_in,
  input wire soft_click_evt,
  input wire finger_presence_evt,
  input wire button_click_evt,
  input wire motion_evt,
  input wire event_service,
  output reg event_pin_o,
  output reg gpio_o,
  output reg mosi_o,
  output reg miso_o,
  output reg pin_test_active_o,
  output reg light_always_lit_o,
  output reg [2:0] light_drive_code_o,
  output reg [8:0] light_current_dma_o,
  output reg image_dump_enable_o,
  output reg image_dump_start_o,
  output reg deep_rest_frame_o
);

  reg [7:0] deep_rest_period_field_reg;
  reg [7:0] light_ctrl_reg;
  reg [7:0] event_ctrl_reg;
  reg [7:0] dump_ctrl_reg;
  reg [1:0] obs_mode_reg;
  reg [7:0] pin_test_lvl_reg;
  reg pin_test_en_reg;
  reg soft_rst_reg;
  reg event_pending_reg;
  reg [7:0] rdata_next;
  reg [8:0] current_next;
  reg event_level_next;
  wire frame_tick;
  wire [3:0] evt_src;
  wire [3:0] evt_hit;
  wire wr_ok;

  assign wr_ok = reg_wr && !soft_rst_reg;
  assign evt_src = {soft_click_evt, finger_presence_evt, button_click_evt, motion_evt};

  // one enable term per source; a mask bit at 1 blocks its source
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_evt
      assign evt_hit[gi] = evt_src[gi] && !event_ctrl_reg[gi];
    end
  endgenerate

  // soft reset is registered so every setting returns to default on the cycle after the key write
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_ok && reg_addr == `SCSR_ADDR_SOFT_RESET && reg_wdata == `SCSR_SOFT_RESET_KEY;
    end
  end

  // software-writable settings; reserved bits are never stored
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      deep_rest_period_field_reg <= `SCSR_RST_DEEP_REST_PERIOD;
      light_ctrl_reg <= `SCSR_RST_LIGHT_CTRL;
      event_ctrl_reg <= `SCSR_RST_EVENT_CTRL;
      dump_ctrl_reg <= `SCSR_RST_DUMP_CTRL;
      pin_test_lvl_reg <= `SCSR_RST_PIN_TEST_LVL;
      pin_test_en_reg <= 1'b0;
    end else if (soft_rst_reg) begin
      deep_rest_period_field_reg <= `SCSR_RST_DEEP_REST_PERIOD;
      light_ctrl_reg <= `SCSR_RST_LIGHT_CTRL;
      event_ctrl_reg <= `SCSR_RST_EVENT_CTRL;
      dump_ctrl_reg <= `SCSR_RST_DUMP_CTRL;
      pin_test_lvl_reg <= `SCSR_RST_PIN_TEST_LVL;
      pin_test_en_reg <= 1'b0;
    end else if (wr_ok) begin
      case (reg_addr)
        `SCSR_ADDR_DEEP_REST_PERIOD: begin
          deep_rest_period_field_reg <= reg_wdata;
        end
        `SCSR_ADDR_LIGHT_CTRL: begin
          light_ctrl_reg <= {4'h0, reg_wdata[`SCSR_LIGHT_ON_BIT:0]};
        end
        `SCSR_ADDR_EVENT_CTRL: begin
          event_ctrl_reg <= {reg_wdata[`SCSR_EVT_POL_BIT], 3'h0, reg_wdata[`SCSR_EVT_MASK_MSB:0]};
        end
        `SCSR_ADDR_DUMP_CTRL: begin
          dump_ctrl_reg <= {7'h00, reg_wdata[`SCSR_DUMP_EN_BIT]};
        end
        `SCSR_ADDR_PIN_TEST_LVL: begin
          pin_test_lvl_reg <= {4'h0, reg_wdata[`SCSR_TEST_EVENT_BIT:0]};
        end
        `SCSR_ADDR_PIN_TEST_EN: begin
          pin_test_en_reg <= reg_wdata[`SCSR_TEST_EN_BIT];
        end
        default: begin
          pin_test_en_reg <= pin_test_en_reg; // unmapped writes are dropped
        end
      endcase
    end
  end

  // observation: frame sets, any write to it clears, a frame in the same cycle wins
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      obs_mode_reg <= 2'h0;
    end else if (frame_done) begin
      obs_mode_reg <= power_mode;
    end else if (soft_rst_reg || (wr_ok && reg_addr == `SCSR_ADDR_FRAME_OBS)) begin
      obs_mode_reg <= 2'h0;
    end
  end

  // event latch: held until serviced; a new event in the service cycle wins
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_pending_reg <= 1'b0;
    end else if (|evt_hit) begin
      event_pending_reg <= 1'b1;
    end else if (event_service || soft_rst_reg) begin
      event_pending_reg <= 1'b0;
    end
  end

  // read mux; write-only and reserved locations read zero
  always @* begin
    rdata_next = 8'h00;
    case (reg_addr)
      `SCSR_ADDR_DEEP_REST_PERIOD: rdata_next = deep_rest_period_field_reg;
      `SCSR_ADDR_LIGHT_CTRL: rdata_next = light_ctrl_reg;
      `SCSR_ADDR_IF_MODE: begin
        rdata_next[`SCSR_IF_BURST_BIT] = burst_mode;
        rdata_next[`SCSR_IF_SPI_BIT] = spi_mode;
        rdata_next[`SCSR_IF_TWI_BIT] = twi_mode;
      end
      `SCSR_ADDR_EVENT_CTRL: rdata_next = event_ctrl_reg;
      `SCSR_ADDR_DUMP_CTRL: rdata_next = dump_ctrl_reg;
      `SCSR_ADDR_FRAME_OBS: rdata_next = {obs_mode_reg, 6'h00};
      `SCSR_ADDR_PIN_STATE: rdata_next = pad_state_in;
      `SCSR_ADDR_PIN_TEST_LVL: rdata_next = pin_test_lvl_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data is captured on the read strobe and held until the next read
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // drive code to current; undefined codes fall back to the 13 mA default
  always @* begin
    case (light_ctrl_reg[`SCSR_LIGHT_CODE_MSB:0])
      `SCSR_LIGHT_CODE_13MA: current_next = `SCSR_LIGHT_DMA_13MA;
      `SCSR_LIGHT_CODE_9P6MA: current_next = `SCSR_LIGHT_DMA_9P6MA;
      `SCSR_LIGHT_CODE_27MA: current_next = `SCSR_LIGHT_DMA_27MA;
      default: current_next = `SCSR_LIGHT_DMA_13MA;
    endcase
  end

  // event pin level: active high when polarity bit is 1, else inverted
  always @* begin
    if (event_ctrl_reg[`SCSR_EVT_POL_BIT]) begin
      event_level_next = event_pending_reg;
    end else begin
      event_level_next = !event_pending_reg;
    end
  end

  // pin outputs; test mode overrides normal function so pads can be checked on the board
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      event_pin_o <= 1'b1;
      gpio_o <= 1'b0;
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
      pin_test_active_o <= 1'b0;
    end else if (pin_test_en_reg) begin
      event_pin_o <= pin_test_lvl_reg[`SCSR_TEST_EVENT_BIT];
      gpio_o <= pin_test_lvl_reg[`SCSR_TEST_GPIO_BIT];
      mosi_o <= pin_test_lvl_reg[`SCSR_TEST_MOSI_BIT];
      miso_o <= pin_test_lvl_reg[`SCSR_TEST_MISO_BIT];
      pin_test_active_o <= 1'b1;
    end else begin
      event_pin_o <= event_level_next;
      gpio_o <= 1'b0;
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
      pin_test_active_o <= 1'b0;
    end
  end

  // light and dump controls; start pulses once per write of 1
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      light_always_lit_o <= 1'b0;
      light_drive_code_o <= 3'h0;
      light_current_dma_o <= `SCSR_LIGHT_DMA_13MA;
      image_dump_enable_o <= 1'b0;
      image_dump_start_o <= 1'b0;
    end else begin
      light_always_lit_o <= light_ctrl_reg[`SCSR_LIGHT_ON_BIT];
      light_drive_code_o <= light_ctrl_reg[`SCSR_LIGHT_CODE_MSB:0];
      light_current_dma_o <= current_next;
      image_dump_enable_o <= dump_ctrl_reg[`SCSR_DUMP_EN_BIT];
      image_dump_start_o <= wr_ok && reg_addr == `SCSR_ADDR_DUMP_CTRL && reg_wdata[`SCSR_DUMP_EN_BIT];
    end
  end

  // deepest rest frame timer on the hibernate tick
  scsr_frame_timer #(
    .HIB_TICK_CYC(HIB_TICK_CYC)
  ) u_timer (
    .clk(clk),
    .rstn(rstn),
    .restart(soft_rst_reg),
    .period(deep_rest_period_field_reg),
    .frame_tick(frame_tick)
  );

  // registered copy keeps the output straight from a flip-flop
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      deep_rest_frame_o <= 1'b0;
    end else begin
      deep_rest_frame_o <= frame_tick;
    end
  end

endmodule // scsr_regs
`default_nettype wire

// ---- scsr_regs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module scsr_regs_monitor #(
  parameter HIB_TICK_CYC = 4
) (
  input wire clk,
  input wire rstn,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  input wire burst_mode,
  input wire spi_mode,
  input wire twi_mode,
  input wire [7:0] pad_state_in,
  input wire soft_click_evt,
  input wire finger_presence_evt,
  input wire button_click_evt,
  input wire motion_evt,
  input wire event_service,
  input wire event_pin_o,
  input wire pin_test_active_o,
  input wire [8:0] light_current_dma_o,
  input wire image_dump_enable_o,
  input wire image_dump_start_o,
  input wire deep_rest_frame_o
);
  // shadow of event control; leads a soft reset by one cycle, so keep events away from it
  reg [7:0] evc_reg;
  wire any_evt = soft_click_evt | finger_presence_evt | button_click_evt | motion_evt;
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      evc_reg <= 8'h04;
    else if (reg_wr && reg_addr == 8'h1d)
      evc_reg <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h3a && reg_wdata == 8'h5a)
      evc_reg <= 8'h04;
  end
  // undefined drive codes fall back to the 13 mA setting
  function [8:0] dma(input [2:0] c);
    dma = (c == 3'h2) ? 9'h060 : (c == 3'h7) ? 9'h10e : 9'h082;
  endfunction
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // level outputs are checked two edges on, which holds for one or two flop stages
  property p_light_cur; reg_wr && reg_addr == 8'h1a |-> ##2 light_current_dma_o == dma($past(reg_wdata[2:0], 2)); endproperty
  a_light_cur: assert property (p_light_cur) else $error("light current wrong");
  property p_dump_en; reg_wr && reg_addr == 8'h28 |-> ##2 image_dump_enable_o == $past(reg_wdata[0], 2); endproperty
  a_dump_en: assert property (p_dump_en) else $error("dump enable wrong");
  property p_dump_start; reg_wr && reg_addr == 8'h28 && reg_wdata[0] |=> image_dump_start_o ##1 !image_dump_start_o; endproperty
  a_dump_start: assert property (p_dump_start) else $error("dump start pulse wrong");
  property p_test_en; reg_wr && reg_addr == 8'h34 |-> ##2 pin_test_active_o == $past(reg_wdata[4], 2); endproperty
  a_test_en: assert property (p_test_en) else $error("pin test enable wrong");
  property p_evt_set; motion_evt && !evc_reg[0] && !pin_test_active_o |-> ##2 event_pin_o == $past(evc_reg[7], 2); endproperty
  a_evt_set: assert property (p_evt_set) else $error("event pin not asserted");
  property p_evt_clr; event_service && !any_evt && !pin_test_active_o |-> ##2 event_pin_o != $past(evc_reg[7], 2); endproperty
  a_evt_clr: assert property (p_evt_clr) else $error("event pin not idle");
  property p_ifmode; reg_rd && reg_addr == 8'h1c |=> reg_rdata == {3'h0, $past(burst_mode), 1'b0, $past(spi_mode), 1'b0, $past(twi_mode)}; endproperty
  a_ifmode: assert property (p_ifmode) else $error("interface status wrong");
  property p_pad; reg_rd && reg_addr == 8'h31 |=> reg_rdata == $past(pad_state_in); endproperty
  a_pad: assert property (p_pad) else $error("pin state wrong");
  property p_rsvd; reg_rd && (reg_addr == 8'h19 || reg_addr == 8'h3a) |=> reg_rdata == 8'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
  property p_frame_pulse; deep_rest_frame_o |=> !deep_rest_frame_o; endproperty
  a_frame_pulse: assert property (p_frame_pulse) else $error("frame pulse too long");
  c_dump: cover property (image_dump_start_o);
  c_service: cover property (event_service ##2 event_pin_o);
  c_frame: cover property (deep_rest_frame_o);
endmodule // scsr_regs_monitor
bind scsr_regs scsr_regs_monitor #(.HIB_TICK_CYC(HIB_TICK_CYC)) u_scsr_regs_monitor (.clk(clk), .rstn(rstn),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .burst_mode(burst_mode), .spi_mode(spi_mode), .twi_mode(twi_mode), .pad_state_in(pad_state_in),
  .soft_click_evt(soft_click_evt), .finger_presence_evt(finger_presence_evt), .button_click_evt(button_click_evt),
  .motion_evt(motion_evt), .event_service(event_service), .event_pin_o(event_pin_o),
  .pin_test_active_o(pin_test_active_o), .light_current_dma_o(light_current_dma_o),
  .image_dump_enable_o(image_dump_enable_o), .image_dump_start_o(image_dump_start_o),
  .deep_rest_frame_o(deep_rest_frame_o));
`default_nettype wire

// ---- scsr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module scsr_host_model (
  input wire clk,
  input wire [7:0] reg_rdata,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // idle bus shows inverted values so a stale address never looks valid
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk);
    {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
  endtask
  // read data is taken once the strobe has been sampled
  task rd(input [7:0] a, output [7:0] d);
    @(negedge clk);
    {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge clk);
    d = reg_rdata;
    {reg_addr, reg_rd} = {~a, 1'b0};
  endtask
  task soft_reset;
    wr(8'h3a, 8'h5a);
  endtask
endmodule // scsr_host_model
`default_nettype wire

// ---- sensor_control_status_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module sensor_control_status_regs_tb;
  logic clk = 1'b0;
  logic rstn, reg_wr, reg_rd, burst_mode, spi_mode, twi_mode, frame_done, event_service;
  logic soft_click_evt, finger_presence_evt, button_click_evt, motion_evt;
  logic event_pin_o, gpio_o, mosi_o, miso_o, pin_test_active_o, light_always_lit_o;
  logic image_dump_enable_o, image_dump_start_o, deep_rest_frame_o;
  logic [1:0] power_mode;
  logic [2:0] light_drive_code_o;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pad_state_in, rd_val;
  logic [8:0] light_current_dma_o;
  int failures = 0, total_checks = 0, cycles = 0;
  logic [2:0] code_tab [0:2] = '{3'h0, 3'h2, 3'h7};
  logic [8:0] dma_tab [0:2] = '{9'h082, 9'h060, 9'h10e};
  always #10 clk = ~clk;
  // short hibernate tick keeps frame periods to at most 964 cycles
  scsr_regs #(.HIB_TICK_CYC(4)) u_scsr_regs (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .burst_mode(burst_mode),
    .spi_mode(spi_mode), .twi_mode(twi_mode), .power_mode(power_mode), .frame_done(frame_done),
    .pad_state_in(pad_state_in), .soft_click_evt(soft_click_evt), .finger_presence_evt(finger_presence_evt),
    .button_click_evt(button_click_evt), .motion_evt(motion_evt), .event_service(event_service),
    .event_pin_o(event_pin_o), .gpio_o(gpio_o), .mosi_o(mosi_o), .miso_o(miso_o),
    .pin_test_active_o(pin_test_active_o), .light_always_lit_o(light_always_lit_o),
    .light_drive_code_o(light_drive_code_o), .light_current_dma_o(light_current_dma_o),
    .image_dump_enable_o(image_dump_enable_o), .image_dump_start_o(image_dump_start_o),
    .deep_rest_frame_o(deep_rest_frame_o));
  scsr_host_model u_scsr_host_model (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  // hang guard, well above the longest frame period measured
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      failures++;
      stop_test;
    end
  end
  task stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input [9:0] e, input [9:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task w(input [7:0] a, input [7:0] d);
    u_scsr_host_model.wr(a, d);
  endtask
  task rc(input [7:0] a, input [7:0] e);
    u_scsr_host_model.rd(a, rd_val);
    chk("read data", {2'h0, e}, {2'h0, rd_val});
  endtask
  // counts cycles between two frame pulses
  task gap(input int e);
    int n;
    n = 0;
    while (deep_rest_frame_o !== 1'b1) cyc(1);
    do begin
      cyc(1);
      n++;
    end while (deep_rest_frame_o !== 1'b1);
    chk("frame period", 10'(e), 10'(n));
  endtask
  // one-cycle pulse on {service, soft, finger, button, motion}, then pin check
  task ev(input [4:0] v, input logic e);
    {event_service, soft_click_evt, finger_presence_evt, button_click_evt, motion_evt} = v;
    cyc(1);
    {event_service, soft_click_evt, finger_presence_evt, button_click_evt, motion_evt} = 5'h00;
    cyc(2);
    chk("event pin", 10'(e), 10'(event_pin_o));
  endtask
  task t_defaults;
    w(8'h19, 8'hff);
    rc(8'h18, 8'h31);
    rc(8'h1d, 8'h04);
    rc(8'h28, 8'h00);
    rc(8'h19, 8'h00);
    rc(8'h3a, 8'h00);
    ev(5'h04, 1'b1);
    gap(200);
  endtask
  task t_light_mode;
    for (int i = 0; i < 3; i++) begin
      w(8'h1a, {4'hf, i[0], code_tab[i]});
      cyc(2);
      chk("light current", 10'(dma_tab[i]), 10'(light_current_dma_o));
      chk("light code", 10'(code_tab[i]), 10'(light_drive_code_o));
      chk("light lit", 10'(i[0]), 10'(light_always_lit_o));
      rc(8'h1a, {4'h0, i[0], code_tab[i]});
    end
    {burst_mode, spi_mode, twi_mode} = 3'b101;
    w(8'h1c, 8'hff);
    rc(8'h1c, 8'h11);
    {burst_mode, spi_mode, twi_mode} = 3'b010;
    rc(8'h1c, 8'h04);
  endtask
  task t_dump_obs;
    w(8'h28, 8'hff);
    chk("dump start", 10'h001, 10'(image_dump_start_o));
    cyc(1);
    chk("dump start", 10'h000, 10'(image_dump_start_o));
    chk("dump enable", 10'h001, 10'(image_dump_enable_o));
    rc(8'h28, 8'h01);
    w(8'h28, 8'h00);
    cyc(1);
    chk("dump enable", 10'h000, 10'(image_dump_enable_o));
    for (int m = 0; m < 4; m++) begin
      power_mode = m[1:0];
      frame_done = 1'b1;
      cyc(1);
      frame_done = 1'b0;
      rc(8'h2e, {m[1:0], 6'h00});
    end
    w(8'h2e, 8'h3f);
    rc(8'h2e, 8'h00);
  endtask
  task t_pins;
    pad_state_in = 8'h1b;
    rc(8'h31, 8'h1b);
    w(8'h33, 8'h05);
    w(8'h34, 8'h10);
    cyc(2);
    chk("test pins", 10'h005, 10'({event_pin_o, gpio_o, mosi_o, miso_o}));
    w(8'h34, 8'h00);
    cyc(2);
    chk("pins after test", 10'h008, 10'({event_pin_o, gpio_o, mosi_o, miso_o}));
  endtask
  task t_event;
    w(8'h1d, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ev(5'h01 << i, 1'b0);
      ev(5'h00, 1'b0);
      ev(5'h10, 1'b1);
    end
    ev(5'h11, 1'b0);
    ev(5'h10, 1'b1);
    w(8'h1d, 8'h8f);
    for (int i = 0; i < 4; i++)
      ev(5'h01 << i, 1'b0);
    w(8'h1d, 8'h80);
    ev(5'h08, 1'b1);
    ev(5'h10, 1'b0);
  endtask
  task t_period_soft;
    w(8'h18, 8'h01);
    gap(8);
    w(8'h18, 8'hf0);
    gap(964);
    u_scsr_host_model.soft_reset;
    cyc(3);
    rc(8'h18, 8'h31);
    rc(8'h1d, 8'h04);
    rc(8'h1a, 8'h00);
  endtask
  initial begin
    {rstn, burst_mode, spi_mode, twi_mode, frame_done, power_mode, pad_state_in} = '0;
    {soft_click_evt, finger_presence_evt, button_click_evt, motion_evt, event_service} = '0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    t_defaults;
    t_light_mode;
    t_dump_obs;
    t_pins;
    t_event;
    t_period_soft;
    stop_test;
  end
endmodule // sensor_control_status_regs_tb
`default_nettype wire
